// ### hw/samd_addr_map.sv
`timescale 1ns/1ps
`include "samd_params.svh"
// Summary of operation
// - One linear space holds code, data, registers and I/O ports.
// - Upper eight address bits select one of 256 segments of 64 KB.
// - Next two address bits select one of four 16 KB data pages.
// - Byte accesses allowed at every address; word accesses only at even addresses.
// - Internal data memories and both register areas sit in segment 0.
// - Instruction fetches go through the program-fetch unit to flash and program RAM.
// - Data transfers go through the data-transfer unit to data RAM and peripherals.
// - System bus links both units for cross-side operand and external traffic.
// - System bus flag marks data-side transfers only; the fetch side has no system bus output.
// - Memories and peripherals have separate buses to allow concurrent work.
// - Alternate 16 KB window aliases the serial channel and CAN register blocks.
// - External I/O area accesses disable pipeline optimisations.
// - Top 4 KB sector of first flash segment is reserved, not user space.
// - A programmable-size program RAM region is write protected.
// - Data RAM has its own interface, separate from the fetch path.
// - Register bank holds 16 words; lower eight also as sixteen byte halves.
// - Upper 256 bytes of the dual-port RAM are bit addressable.
// - Any dual-port RAM location used as general register is bit addressable.
// - Parts of both register areas are bit addressable too.
// - Standby RAM has a dedicated interface and keeps contents in power-down.
module samd_addr_map #(
  parameter int PRAM_PROT_W = 15
) (
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  // Program-fetch side
  input  wire logic                    fetch_req,
  input  wire logic [23:0]             fetch_addr,
  output logic                         fetch_ack,
  output samd_pkg::samd_target_type    fetch_target,
  output logic [23:0]                  fetch_local,
  output logic                         fetch_trap,
  // Data-transfer side
  input  wire logic                    data_req,
  input  wire logic                    data_write,
  input  wire logic                    data_word,
  input  wire logic                    data_bit,
  input  wire logic                    data_gpr,
  input  wire logic [23:0]             data_addr,
  output logic                         data_ack,
  output samd_pkg::samd_target_type    data_target,
  output logic [23:0]                  data_local,
  output logic                         data_trap,
  output logic                         data_ext_io,
  output logic                         data_sysbus,
  output logic                         data_be_lo,
  output logic                         data_be_hi,
  output logic [7:0]                   data_segment,
  output logic [1:0]                   data_page,
  // General register access
  input  wire logic                    gpr_req,
  input  wire logic [23:0]             gpr_bank_base,
  input  wire logic [3:0]              gpr_num,
  input  wire logic                    gpr_byte,
  output logic                         gpr_ack,
  output logic [23:0]                  gpr_addr,
  output logic                         gpr_fault,
  // Program RAM write protection
  input  wire logic [PRAM_PROT_W-1:0]  pram_prot_size,
  // Standby RAM dedicated port
  input  wire logic                    sby_req,
  input  wire logic [12:0]             sby_addr,
  output logic                         sby_sel,
  output logic [12:0]                  sby_local
);
  import samd_pkg::*;

  samd_target_type f_tgt;
  samd_target_type d_tgt;
  logic [23:0]     f_loc;
  logic [23:0]     d_loc;
  logic            d_extio;
  logic            d_bitok;
  logic [23:0]     g_addr;
  logic            g_bad;

  // Two decoders so fetch and data sides never serialise
  samd_range_decode u_fetch_dec (
    .addr       (fetch_addr),
    .target     (f_tgt),
    .local_addr (f_loc),
    .ext_io     (),
    .bit_ok     ()
  );
  samd_range_decode u_data_dec (
    .addr       (data_addr),
    .target     (d_tgt),
    .local_addr (d_loc),
    .ext_io     (d_extio),
    .bit_ok     (d_bitok)
  );
  samd_gpr_map u_gpr (
    .bank_base (gpr_bank_base),
    .reg_num   (gpr_num),
    .byte_mode (gpr_byte),
    .gpr_addr  (g_addr),
    .gpr_bad   (g_bad)
  );

  // Fetch may only reach program memory or external code
  wire f_legal = (f_tgt == SAMD_TGT_FLASH) || (f_tgt == SAMD_TGT_PRAM) ||
                 (f_tgt == SAMD_TGT_EPRAM) || (f_tgt == SAMD_TGT_EXT);
  // Words must be even; bytes anywhere
  wire d_misalign = data_word && data_addr[0];
  // Program RAM offset below the protect limit blocks writes
  wire [23:0] d_pram_off = data_addr & `SAMD_PRAM_MASK;
  wire d_is_pram = (d_tgt == SAMD_TGT_PRAM) || (d_tgt == SAMD_TGT_EPRAM);
  wire d_prot    = d_is_pram && data_write &&
                   (d_pram_off[PRAM_PROT_W-1:0] < pram_prot_size);
  // Bit ops legal on bit windows or any dual-port RAM word used as register
  wire d_bit_bad = data_bit && !(d_bitok || (data_gpr && d_tgt == SAMD_TGT_DUAL_PORT_RAM));
  wire d_trap    = (d_tgt == SAMD_TGT_TRAP) || (d_tgt == SAMD_TGT_NONE) ||
                   d_misalign || d_prot || d_bit_bad;
  // Cross-unit traffic goes over the system bus
  wire d_sys = (d_tgt == SAMD_TGT_FLASH) || d_is_pram || (d_tgt == SAMD_TGT_EXT) ||
               (d_tgt == SAMD_TGT_CAN) || (d_tgt == SAMD_TGT_SER);
  wire g_dp  = (g_addr >= `SAMD_DP_LO) && (g_addr <= `SAMD_DP_HI);

  // Each path registered on its own; no shared state between sides
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fetch_ack    <= 1'b0;
      fetch_target <= SAMD_TGT_NONE;
      fetch_local  <= 24'h000000;
      fetch_trap   <= 1'b0;
    end else begin
      fetch_ack    <= fetch_req;
      fetch_target <= fetch_req ? f_tgt : SAMD_TGT_NONE;
      fetch_local  <= f_loc;
      fetch_trap   <= fetch_req && !f_legal;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      data_ack     <= 1'b0;
      data_target  <= SAMD_TGT_NONE;
      data_local   <= 24'h000000;
      data_trap    <= 1'b0;
      data_ext_io  <= 1'b0;
      data_sysbus  <= 1'b0;
      data_be_lo   <= 1'b0;
      data_be_hi   <= 1'b0;
      data_segment <= 8'h00;
      data_page    <= 2'h0;
    end else begin
      data_ack     <= data_req;
      data_target  <= (data_req && !d_trap) ? d_tgt : SAMD_TGT_NONE;
      data_local   <= d_loc;
      data_trap    <= data_req && d_trap;
      data_ext_io  <= data_req && d_extio;
      data_sysbus  <= data_req && !d_trap && d_sys;
      data_be_lo   <= data_req && (data_word || !data_addr[0]);
      data_be_hi   <= data_req && (data_word || data_addr[0]);
      data_segment <= data_addr[`SAMD_SEG_MSB:`SAMD_SEG_LSB];
      data_page    <= data_addr[`SAMD_PAGE_MSB:`SAMD_PAGE_LSB];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      gpr_ack   <= 1'b0;
      gpr_addr  <= 24'h000000;
      gpr_fault <= 1'b0;
      sby_sel   <= 1'b0;
      sby_local <= 13'h0000;
    end else begin
      gpr_ack   <= gpr_req;
      gpr_addr  <= g_addr;
      gpr_fault <= gpr_req && (g_bad || !g_dp);
      sby_sel   <= sby_req;
      sby_local <= sby_addr;
    end
  end

  AST_SEG_PAGE: assert property (@(posedge core_clk) disable iff (reset)
    data_req |=> data_segment == $past(data_addr[23:16]) &&
                 data_page == $past(data_addr[15:14]))
    else $error("segment or page field wrong");
  AST_FETCH_ACK: assert property (@(posedge core_clk) disable iff (reset)
    fetch_req |=> fetch_ack)
    else $error("fetch not acknowledged");
  AST_FETCH_DATA_TRAP: assert property (@(posedge core_clk) disable iff (reset)
    fetch_req && f_tgt == SAMD_TGT_DRAM |=> fetch_trap)
    else $error("fetch into data RAM not trapped");
  AST_RSV_FLASH: assert property (@(posedge core_clk) disable iff (reset)
    data_req && data_addr >= 24'hc0f000 && data_addr <= 24'hc0ffff |=> data_trap)
    else $error("reserved flash sector reachable");
  AST_ALIAS: assert property (@(posedge core_clk) disable iff (reset)
    data_req && !data_word && !data_bit && data_addr >= 24'h208000 &&
    data_addr <= 24'h209fff |=> data_target == SAMD_TGT_CAN)
    else $error("alias window not routed to CAN");
  AST_EXT_IO: assert property (@(posedge core_clk) disable iff (reset)
    data_req && data_addr >= 24'h210000 && data_addr <= 24'h3fffff |=> data_ext_io)
    else $error("external I/O flag missing");
  AST_PROTECT: assert property (@(posedge core_clk) disable iff (reset)
    data_req && data_write && d_tgt == SAMD_TGT_PRAM &&
    d_pram_off[PRAM_PROT_W-1:0] < pram_prot_size |=> data_trap &&
    data_target == SAMD_TGT_NONE)
    else $error("protected program RAM write passed");
  AST_TOP_TRAP: assert property (@(posedge core_clk) disable iff (reset)
    data_req && data_addr >= 24'hf00000 && data_addr < 24'hffff00 |=> data_trap)
    else $error("reserved top region not trapped");
  AST_WORD_BE: assert property (@(posedge core_clk) disable iff (reset)
    data_req && data_word |=> data_be_lo && data_be_hi)
    else $error("word access lost a byte lane");
  AST_DATA_RAM: assert property (@(posedge core_clk) disable iff (reset)
    data_req && !data_word && !data_bit && data_addr >= 24'h00a000 &&
    data_addr <= 24'h00dfff |=> data_target == SAMD_TGT_DRAM && !data_sysbus)
    else $error("data RAM not on own interface");
  AST_GPR_BYTE: assert property (@(posedge core_clk) disable iff (reset)
    gpr_req && gpr_byte && gpr_num[3] && !gpr_bank_base[0] &&
    gpr_bank_base >= 24'h00f600 && gpr_bank_base <= 24'h00fdf0 |=> !gpr_fault)
    else $error("upper byte halves refused");
  AST_BIT_GPR: assert property (@(posedge core_clk) disable iff (reset)
    data_req && data_bit && data_gpr && !data_word && d_tgt == SAMD_TGT_DUAL_PORT_RAM
    |=> !data_trap)
    else $error("register bit access trapped");
  AST_CONCURRENT: assert property (@(posedge core_clk) disable iff (reset)
    fetch_req && data_req |=> fetch_ack && data_ack)
    else $error("sides serialised");
  AST_BIT_DP: assert property (@(posedge core_clk) disable iff (reset)
    data_req && data_bit && !data_word && data_addr >= 24'h00fd00 &&
    data_addr <= 24'h00fdff |=> !data_trap)
    else $error("bit window trapped");

  COV_BOTH: cover property (@(posedge core_clk) disable iff (reset) fetch_req && data_req);
  COV_ALIAS: cover property (@(posedge core_clk) disable iff (reset)
    data_req && d_tgt == SAMD_TGT_SER && data_addr[23:12] == 12'h20a);
  COV_PROT: cover property (@(posedge core_clk) disable iff (reset) data_req && d_prot);
  COV_MIRROR: cover property (@(posedge core_clk) disable iff (reset)
    fetch_req && f_tgt == SAMD_TGT_PRAM && fetch_addr[18:15] != 4'h0);
endmodule

// ### hw/samd_params.svh
`ifndef SAMD_PARAMS_SVH
`define SAMD_PARAMS_SVH
`define SAMD_ADDR_W        24
`define SAMD_SEG_MSB       23
`define SAMD_SEG_LSB       16
`define SAMD_PAGE_MSB      15
`define SAMD_PAGE_LSB      14
`define SAMD_EXT0_LO       24'h000000
`define SAMD_EXT0_HI       24'h007fff
`define SAMD_DRAM_RSV_LO   24'h008000
`define SAMD_DRAM_LO       24'h00a000
`define SAMD_DRAM_HI       24'h00dfff
`define SAMD_XREG_LO       24'h00e000
`define SAMD_XREG_HI       24'h00efff
`define SAMD_EREG_LO       24'h00f000
`define SAMD_EREG_HI       24'h00f1ff
`define SAMD_DP_RSV_LO     24'h00f200
`define SAMD_DP_LO         24'h00f600
`define SAMD_DP_HI         24'h00fdff
`define SAMD_DP_BIT_LO     24'h00fd00
`define SAMD_SREG_LO       24'h00fe00
`define SAMD_SREG_HI       24'h00ffff
`define SAMD_EXT1_LO       24'h010000
`define SAMD_EXT1_HI       24'h1fffff
`define SAMD_CAN_LO        24'h200000
`define SAMD_CAN_HI        24'h203fff
`define SAMD_SER_LO        24'h204000
`define SAMD_SER_HI        24'h205fff
`define SAMD_ALIAS_LO      24'h208000
`define SAMD_ALIAS_HI      24'h20bfff
`define SAMD_EXTIO_LO      24'h210000
`define SAMD_EXTIO_HI      24'h3fffff
`define SAMD_EXT2_LO       24'h400000
`define SAMD_EXT2_HI       24'hbfffff
`define SAMD_FLASH_LO      24'hc00000
`define SAMD_FLASH_HI      24'hccffff
`define SAMD_FLASH_RSV_LO  24'hc0f000
`define SAMD_FLASH_RSV_HI  24'hc0ffff
`define SAMD_PRAM_LO       24'he00000
`define SAMD_PRAM_HI       24'he7ffff
`define SAMD_EPRAM_LO      24'he80000
`define SAMD_EPRAM_HI      24'hefffff
`define SAMD_TRAP_LO       24'hf00000
`define SAMD_IBUS_LO       24'hffff00
`define SAMD_PRAM_MASK     24'h007fff
`define SAMD_SREG_BIT_LO   24'h00ff00
`define SAMD_EREG_BIT_LO   24'h00f100
`endif

// ### hw/samd_pkg.sv
package samd_pkg;
  typedef enum logic [3:0] {
    SAMD_TGT_NONE   = 4'h0,
    SAMD_TGT_EXT    = 4'h1,
    SAMD_TGT_DRAM   = 4'h2,
    SAMD_TGT_XREG   = 4'h3,
    SAMD_TGT_EREG   = 4'h4,
    SAMD_TGT_DUAL_PORT_RAM  = 4'h5,
    SAMD_TGT_SREG   = 4'h6,
    SAMD_TGT_CAN    = 4'h7,
    SAMD_TGT_SER    = 4'h8,
    SAMD_TGT_FLASH  = 4'h9,
    SAMD_TGT_PRAM   = 4'ha,
    SAMD_TGT_EPRAM  = 4'hb,
    SAMD_TGT_IBUS   = 4'hc,
    SAMD_TGT_TRAP   = 4'hd
  } samd_target_type;
  typedef enum logic [2:0] {
    SAMD_ST_IDLE = 3'b001,
    SAMD_ST_BUSY = 3'b010,
    SAMD_ST_DONE = 3'b100
  } samd_state_type;
endpackage

// ### hw/samd_range_decode.sv
`timescale 1ns/1ps
`include "samd_params.svh"
// Pure address classifier shared by both paths
module samd_range_decode (
  input  wire logic [23:0]               addr,
  output samd_pkg::samd_target_type      target,
  output logic [23:0]                    local_addr,
  output logic                           ext_io,
  output logic                           bit_ok
);
  import samd_pkg::*;
  function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo,
                                  input logic [23:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction
  wire seg0      = (addr[`SAMD_SEG_MSB:`SAMD_SEG_LSB] == 8'h00);
  wire is_dp     = in_rng(addr, `SAMD_DP_LO, `SAMD_DP_HI);
  wire is_alias  = in_rng(addr, `SAMD_ALIAS_LO, `SAMD_ALIAS_HI);
  wire alias_ser = addr[13];
  // Alias window folds onto the original blocks
  wire [23:0] alias_addr = alias_ser ? (`SAMD_SER_LO | {11'h000, addr[12:0]})
                                     : (`SAMD_CAN_LO | {10'h000, addr[13:0]});
  always_comb begin
    target     = SAMD_TGT_NONE;
    local_addr = addr;
    if (seg0) begin
      if (in_rng(addr, `SAMD_EXT0_LO, `SAMD_EXT0_HI))        target = SAMD_TGT_EXT;
      else if (in_rng(addr, `SAMD_DRAM_LO, `SAMD_DRAM_HI))   target = SAMD_TGT_DRAM;
      else if (in_rng(addr, `SAMD_XREG_LO, `SAMD_XREG_HI))   target = SAMD_TGT_XREG;
      else if (in_rng(addr, `SAMD_EREG_LO, `SAMD_EREG_HI))   target = SAMD_TGT_EREG;
      else if (is_dp)                                        target = SAMD_TGT_DUAL_PORT_RAM;
      else if (in_rng(addr, `SAMD_SREG_LO, `SAMD_SREG_HI))   target = SAMD_TGT_SREG;
    end else if (in_rng(addr, `SAMD_EXT1_LO, `SAMD_EXT1_HI) ||
                 in_rng(addr, `SAMD_EXTIO_LO, `SAMD_EXTIO_HI) ||
                 in_rng(addr, `SAMD_EXT2_LO, `SAMD_EXT2_HI)) begin
      target = SAMD_TGT_EXT;
    end else if (in_rng(addr, `SAMD_CAN_LO, `SAMD_CAN_HI)) begin
      target = SAMD_TGT_CAN;
    end else if (in_rng(addr, `SAMD_SER_LO, `SAMD_SER_HI)) begin
      target = SAMD_TGT_SER;
    end else if (is_alias) begin
      target     = alias_ser ? SAMD_TGT_SER : SAMD_TGT_CAN;
      local_addr = alias_addr;
    end else if (in_rng(addr, `SAMD_FLASH_LO, `SAMD_FLASH_HI)) begin
      // Internal parameter sector is never a user target
      if (!in_rng(addr, `SAMD_FLASH_RSV_LO, `SAMD_FLASH_RSV_HI)) target = SAMD_TGT_FLASH;
    end else if (in_rng(addr, `SAMD_PRAM_LO, `SAMD_PRAM_HI)) begin
      target     = SAMD_TGT_PRAM;
      local_addr = `SAMD_PRAM_LO | (addr & `SAMD_PRAM_MASK);
    end else if (in_rng(addr, `SAMD_EPRAM_LO, `SAMD_EPRAM_HI)) begin
      target     = SAMD_TGT_EPRAM;
      local_addr = `SAMD_EPRAM_LO | (addr & `SAMD_PRAM_MASK);
    end else if (addr >= `SAMD_IBUS_LO) begin
      target = SAMD_TGT_IBUS;
    end else if (addr >= `SAMD_TRAP_LO) begin
      target = SAMD_TGT_TRAP;
    end
  end
  assign ext_io = in_rng(addr, `SAMD_EXTIO_LO, `SAMD_EXTIO_HI);
  // Bit access: top of dual-port RAM and parts of both register areas
  assign bit_ok = in_rng(addr, `SAMD_DP_BIT_LO, `SAMD_DP_HI) ||
                  in_rng(addr, `SAMD_SREG_BIT_LO, `SAMD_SREG_HI) ||
                  in_rng(addr, `SAMD_EREG_BIT_LO, `SAMD_EREG_HI);
endmodule

// ### hw/samd_gpr_map.sv
`timescale 1ns/1ps
// Maps a general register number onto a dual-port RAM byte address
module samd_gpr_map (
  input  wire logic [23:0] bank_base,
  input  wire logic [3:0]  reg_num,
  input  wire logic        byte_mode,
  output logic [23:0]      gpr_addr,
  output logic             gpr_bad
);
  // Sixteen byte halves cover the lower eight words, low half first
  assign gpr_addr = byte_mode ? (bank_base + {20'h00000, reg_num})
                              : (bank_base + {19'h00000, reg_num, 1'b0});
  // Odd bank base would split every word register
  assign gpr_bad  = bank_base[0];
endmodule

// ### tb/samd_bus_model.sv
`timescale 1ns/1ps
// Far-side sink: counts each answered data transfer once, by outcome
module samd_bus_model (
  input  wire logic                       core_clk,
  input  wire logic                       reset,
  input  wire logic                       data_ack,
  input  wire logic                       data_trap,
  input  wire samd_pkg::samd_target_type  data_target,
  output int                              good_cnt,
  output int                              trap_cnt
);
  import samd_pkg::*;
  wire logic refused = data_trap || (data_target == SAMD_TGT_NONE);
  always_ff @(posedge core_clk) begin
    if (reset) begin
      good_cnt <= 0;
      trap_cnt <= 0;
    end else if (data_ack && refused) begin
      trap_cnt <= trap_cnt + 1;
    end else if (data_ack) begin
      good_cnt <= good_cnt + 1;
    end
  end
endmodule

// ### tb/tb_system_address_map_decoder.sv
`timescale 1ns/1ps
module tb_system_address_map_decoder;
  import samd_pkg::*;
  typedef struct {logic [23:0] a; logic [3:0] f; samd_target_type t; logic [23:0] l;} samd_row_type;
  logic core_clk, reset, fetch_req, data_req, data_write, data_word, data_bit, data_gpr;
  logic gpr_req, gpr_byte, sby_req;
  logic [23:0] fetch_addr, data_addr, gpr_bank_base, fetch_local, data_local, gpr_addr;
  logic [3:0]  gpr_num;
  logic [14:0] pram_prot_size;
  logic [12:0] sby_addr, sby_local;
  logic        fetch_ack, fetch_trap, data_ack, data_trap, data_ext_io, data_sysbus;
  logic        data_be_lo, data_be_hi, gpr_ack, gpr_fault, sby_sel;
  logic [7:0]  data_segment;
  logic [1:0]  data_page;
  samd_target_type fetch_target, data_target;
  int          good_cnt, trap_cnt, miscompares, tests_run, cycles, exp_good;
  samd_row_type rows[$];

  samd_addr_map #(.PRAM_PROT_W(15)) dut_u (.core_clk(core_clk), .reset(reset),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_ack(fetch_ack),
    .fetch_target(fetch_target), .fetch_local(fetch_local), .fetch_trap(fetch_trap),
    .data_req(data_req), .data_write(data_write), .data_word(data_word), .data_bit(data_bit),
    .data_gpr(data_gpr), .data_addr(data_addr), .data_ack(data_ack), .data_target(data_target),
    .data_local(data_local), .data_trap(data_trap), .data_ext_io(data_ext_io),
    .data_sysbus(data_sysbus), .data_be_lo(data_be_lo), .data_be_hi(data_be_hi),
    .data_segment(data_segment), .data_page(data_page), .gpr_req(gpr_req),
    .gpr_bank_base(gpr_bank_base), .gpr_num(gpr_num), .gpr_byte(gpr_byte), .gpr_ack(gpr_ack),
    .gpr_addr(gpr_addr), .gpr_fault(gpr_fault), .pram_prot_size(pram_prot_size),
    .sby_req(sby_req), .sby_addr(sby_addr), .sby_sel(sby_sel), .sby_local(sby_local));

  samd_bus_model model_u (.core_clk(core_clk), .reset(reset), .data_ack(data_ack),
    .data_trap(data_trap), .data_target(data_target), .good_cnt(good_cnt), .trap_cnt(trap_cnt));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic stop_test();
    $display("compares %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Ceiling well above the roughly 65 cycles the sequence needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic check_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic check_vec(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t value got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_tgt(input samd_target_type got, input samd_target_type exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t target got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic add(input logic [23:0] a, input logic [3:0] f, input samd_target_type t,
                     input logic [23:0] l);
    rows.push_back('{a, f, t, l});
  endtask

  // Flags are {write, word, bit, general register}; NONE means a trap is expected
  task automatic check_row(input samd_row_type r);
    logic tr;
    logic sb;
    logic fok;
    tr = (r.t == SAMD_TGT_NONE);
    sb = r.t inside {SAMD_TGT_FLASH, SAMD_TGT_PRAM, SAMD_TGT_EPRAM, SAMD_TGT_EXT,
                     SAMD_TGT_CAN, SAMD_TGT_SER};
    fok = r.t inside {SAMD_TGT_FLASH, SAMD_TGT_PRAM, SAMD_TGT_EPRAM, SAMD_TGT_EXT};
    check_bit(data_ack, 1'b1);
    check_tgt(data_target, r.t);
    check_bit(data_trap, tr);
    check_bit(data_ext_io, r.a >= 24'h210000 && r.a <= 24'h3fffff);
    check_vec({16'h0000, data_segment}, {16'h0000, r.a[23:16]});
    check_vec({22'h000000, data_page}, {22'h000000, r.a[15:14]});
    if (!tr) begin
      check_vec(data_local, r.l);
      check_bit(data_sysbus, sb);
      check_bit(data_be_lo, r.f[2] | ~r.a[0]);
      check_bit(data_be_hi, r.f[2] | r.a[0]);
    end
    // Fetch rides alongside every row to load both paths at once; checked on untrapped non-write, non-bit rows
    if (!tr && !r.f[3] && !r.f[1]) begin
      check_bit(fetch_ack, 1'b1);
      check_bit(fetch_trap, ~fok);
      if (fok) check_vec(fetch_local, r.l);
      if (fok) check_tgt(fetch_target, r.t);
    end
  endtask

  task automatic gpr_chk(input logic [23:0] base, input logic [3:0] n, input logic b,
                         input logic [23:0] ea, input logic ef);
    @(posedge core_clk);
    gpr_req <= 1'b1;
    gpr_bank_base <= base;
    gpr_num <= n;
    gpr_byte <= b;
    @(posedge core_clk);
    gpr_req <= 1'b0;
    #1;
    check_bit(gpr_ack, 1'b1);
    check_bit(gpr_fault, ef);
    if (!ef) check_vec(gpr_addr, ea);
  endtask

  initial begin
    {reset, fetch_req, data_req, data_write, data_word, data_bit, data_gpr} = 7'h7f;
    {fetch_req, data_req, gpr_req, gpr_byte, sby_req} = 5'h00;
    {data_write, data_word, data_bit, data_gpr} = 4'h0;
    {fetch_addr, data_addr, gpr_bank_base} = {3{24'h000000}};
    gpr_num = 4'h0;
    sby_addr = 13'h0000;
    pram_prot_size = 15'h0100;
    {miscompares, tests_run, cycles, exp_good} = 0;
    add(24'h00a000, 4'b0100, SAMD_TGT_DRAM, 24'h00a000);
    add(24'h00dfff, 4'b0000, SAMD_TGT_DRAM, 24'h00dfff);
    add(24'h008000, 4'b0000, SAMD_TGT_NONE, 24'h0);
    add(24'h00e000, 4'b0100, SAMD_TGT_XREG, 24'h00e000);
    add(24'h00f000, 4'b0000, SAMD_TGT_EREG, 24'h00f000);
    add(24'h00f200, 4'b0000, SAMD_TGT_NONE, 24'h0);
    add(24'h00f600, 4'b0100, SAMD_TGT_DUAL_PORT_RAM, 24'h00f600);
    add(24'h00fe00, 4'b0100, SAMD_TGT_SREG, 24'h00fe00);
    add(24'h000000, 4'b0000, SAMD_TGT_EXT, 24'h000000);
    add(24'h010000, 4'b0100, SAMD_TGT_EXT, 24'h010000);
    add(24'h200000, 4'b0100, SAMD_TGT_CAN, 24'h200000);
    add(24'h204001, 4'b0000, SAMD_TGT_SER, 24'h204001);
    add(24'h206000, 4'b0000, SAMD_TGT_NONE, 24'h0);
    add(24'h208004, 4'b0100, SAMD_TGT_CAN, 24'h200004);
    add(24'h20a002, 4'b0100, SAMD_TGT_SER, 24'h204002);
    add(24'h20c000, 4'b0000, SAMD_TGT_NONE, 24'h0);
    add(24'h210000, 4'b0100, SAMD_TGT_EXT, 24'h210000);
    add(24'h3ffffe, 4'b0100, SAMD_TGT_EXT, 24'h3ffffe);
    add(24'h400000, 4'b1100, SAMD_TGT_EXT, 24'h400000);
    add(24'hc00000, 4'b0100, SAMD_TGT_FLASH, 24'hc00000);
    add(24'hc0f000, 4'b0000, SAMD_TGT_NONE, 24'h0);
    add(24'hc0fffe, 4'b0100, SAMD_TGT_NONE, 24'h0);
    add(24'hc10000, 4'b0100, SAMD_TGT_FLASH, 24'hc10000);
    add(24'hcd0000, 4'b0000, SAMD_TGT_NONE, 24'h0);
    add(24'he00000, 4'b0100, SAMD_TGT_PRAM, 24'he00000);
    add(24'he08002, 4'b0100, SAMD_TGT_PRAM, 24'he00002);
    add(24'he88010, 4'b0100, SAMD_TGT_EPRAM, 24'he80010);
    add(24'he00010, 4'b1100, SAMD_TGT_NONE, 24'h0);
    add(24'he000ff, 4'b1000, SAMD_TGT_NONE, 24'h0);
    add(24'he00100, 4'b1100, SAMD_TGT_PRAM, 24'he00100);
    add(24'he80010, 4'b1000, SAMD_TGT_NONE, 24'h0);
    add(24'hf00000, 4'b0000, SAMD_TGT_NONE, 24'h0);
    add(24'hffff00, 4'b0100, SAMD_TGT_IBUS, 24'hffff00);
    add(24'h00a001, 4'b0100, SAMD_TGT_NONE, 24'h0);
    add(24'h00fd00, 4'b0010, SAMD_TGT_DUAL_PORT_RAM, 24'h00fd00);
    add(24'h00fcff, 4'b0010, SAMD_TGT_NONE, 24'h0);
    add(24'h00f600, 4'b0011, SAMD_TGT_DUAL_PORT_RAM, 24'h00f600);
    add(24'h00ff00, 4'b0010, SAMD_TGT_SREG, 24'h00ff00);
    add(24'h00fe00, 4'b0010, SAMD_TGT_NONE, 24'h0);
    add(24'h00f100, 4'b0010, SAMD_TGT_EREG, 24'h00f100);
    add(24'h00f000, 4'b0010, SAMD_TGT_NONE, 24'h0);
    @(posedge core_clk);
    @(posedge core_clk);
    reset <= 1'b0;
    #1;
    check_bit(data_ack | fetch_ack | gpr_ack | sby_sel, 1'b0);
    check_tgt(data_target, SAMD_TGT_NONE);
    $display("test reset done");
    // Rows issued back to back; each answer is checked while the next is taken
    for (int i = 0; i <= rows.size(); i++) begin
      @(posedge core_clk);
      data_req <= (i < rows.size());
      fetch_req <= (i < rows.size());
      if (i < rows.size()) begin
        data_addr <= rows[i].a;
        fetch_addr <= rows[i].a;
        {data_write, data_word, data_bit, data_gpr} <= rows[i].f;
        if (rows[i].t != SAMD_TGT_NONE) exp_good++;
      end
      #1;
      if (i > 0) check_row(rows[i-1]);
    end
    @(posedge core_clk);
    #1;
    check_vec(24'(good_cnt), 24'(exp_good));
    check_vec(24'(trap_cnt), 24'(rows.size() - exp_good));
    $display("test address table done");
    gpr_chk(24'h00f600, 4'h5, 1'b0, 24'h00f60a, 1'b0);
    gpr_chk(24'h00f600, 4'h5, 1'b1, 24'h00f605, 1'b0);
    gpr_chk(24'h00f600, 4'hf, 1'b0, 24'h00f61e, 1'b0);
    gpr_chk(24'h00f600, 4'h8, 1'b1, 24'h00f608, 1'b0);
    gpr_chk(24'h00f601, 4'h0, 1'b0, 24'h0, 1'b1);
    gpr_chk(24'h00fdf0, 4'hf, 1'b0, 24'h0, 1'b1);
    $display("test general registers done");
    @(posedge core_clk);
    sby_req <= 1'b1;
    sby_addr <= 13'h1abc;
    @(posedge core_clk);
    sby_req <= 1'b0;
    #1;
    check_bit(sby_sel, 1'b1);
    check_vec({11'h000, sby_local}, 24'h001abc);
    $display("test standby port done");
    @(posedge core_clk);
    data_req <= 1'b1;
    data_addr <= 24'h00a000;
    reset <= 1'b1;
    @(posedge core_clk);
    data_req <= 1'b0;
    #1;
    check_bit(data_ack, 1'b0);
    check_tgt(data_target, SAMD_TGT_NONE);
    // Release after the request drops so no check straddles reset
    @(posedge core_clk);
    reset <= 1'b0;
    pram_prot_size <= 15'h0000;
    @(posedge core_clk);
    data_req <= 1'b1;
    data_addr <= 24'he00010;
    {data_write, data_word, data_bit, data_gpr} <= 4'b1100;
    @(posedge core_clk);
    data_req <= 1'b0;
    #1;
    check_bit(data_ack, 1'b1);
    check_tgt(data_target, SAMD_TGT_PRAM);
    check_bit(data_trap, 1'b0);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule
